// *** design/arp_cfg.svh ***
`ifndef ARP_CFG_SVH
`define ARP_CFG_SVH

// ----------------------------------------------------------------------------
// Readout port constants
// ----------------------------------------------------------------------------

// Number of channels in one conversion set.
`define ARP_NUM_CHANNELS 8
// Bits in one channel result.
`define ARP_RESULT_BITS 16
// Channels carried by each serial line.
`define ARP_CH_PER_LINE 4
// Level of the interface select input that picks the 16-bit parallel mode.
`define ARP_IFSEL_PARALLEL 1'b0
// Level of the msb/byte select input that picks byte mode.
`define ARP_MSBSEL_BYTE 1'b1
// Standby level of the range input while power-down is requested.
`define ARP_RANGE_STANDBY 1'b1
// Serial clock falling edges after which the first-channel flag drops.
`define ARP_FLAG_SCLK_FALLS 5'h10

`endif

// *** design/arp_pkg.sv ***
// ----------------------------------------------------------------------------
// Readout port types
// ----------------------------------------------------------------------------
package arp_pkg;

  // Interface mode decoded from the select pins.
  typedef enum logic [1:0]
  {
    ARP_MODE_PAR16  = 2'b00,
    ARP_MODE_BYTE   = 2'b01,
    ARP_MODE_SERIAL = 2'b10
  } arp_mode_t;

  // Power state decoded from standby and range.
  typedef enum logic [1:0]
  {
    ARP_PWR_ACTIVE   = 2'b00,
    ARP_PWR_STANDBY  = 2'b01,
    ARP_PWR_SHUTDOWN = 2'b10
  } arp_pwr_t;

  // Host strobes after synchronisation, with their edges.
  typedef struct packed
  {
    logic cs_n;
    logic cs_fall;
    logic cs_rise;
    logic rd_n;
    logic rd_fall;
    logic sclk_rise;
    logic sclk_fall;
  } arp_strobe_t;

  // Pin drive bundle for the result bus.
  typedef struct packed
  {
    logic [15:0] data;
    logic [15:0] oe;
  } arp_bus_t;

endpackage

// *** design/arp_readout.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "arp_cfg.svh"

module arp_readout
#(
  parameter int NUM_CH = `ARP_NUM_CHANNELS,
  parameter int RBITS  = `ARP_RESULT_BITS
)
(
  // Clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset_n,
  // Conversion results, channel 1 in the lowest slice
  input  wire logic [NUM_CH*RBITS-1:0] i_results,
  // Host strobes, asynchronous to the core clock
  input  wire logic                    i_cs_n,
  input  wire logic                    i_rd_sclk,
  // Mode and power pins
  input  wire logic                    i_interface_select,
  input  wire logic                    i_msb_or_byte_select,
  input  wire logic                    i_byte_order_select,
  input  wire logic                    i_standby_n,
  input  wire logic                    i_range,
  // Result bus pins
  output logic [15:0]                  o_result_bus,
  output logic [15:0]                  o_result_bus_oe,
  // Serial lines, sharing result bus bits 7 and 8 on the package
  output logic                         o_serial_out_a,
  output logic                         o_serial_out_b,
  output logic                         o_serial_oe,
  // First-channel flag pin
  output logic                         o_first_channel_flag,
  output logic                         o_first_channel_flag_oe,
  // Power state
  output arp_pkg::arp_pwr_t            o_power_state
);

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------

  arp_pkg::arp_strobe_t stb;        // Synchronised strobes.
  logic                 rd_rise;    // Read/serial-clock rising edge.
  logic                 rd_fall;    // Read/serial-clock falling edge.
  logic                 rd_level;   // Read/serial-clock level.
  logic                 cs_level;   // Select level.
  logic                 cs_rise;    // Select rising edge.
  logic                 cs_fall;    // Select falling edge.

  arp_sync #(.RESET_LEVEL(1'b1)) u_cs_sync
  (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_cs_n),
    .o_level    (cs_level),
    .o_rise     (cs_rise),
    .o_fall     (cs_fall)
  );

  arp_sync #(.RESET_LEVEL(1'b1)) u_rd_sync
  (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_rd_sclk),
    .o_level    (rd_level),
    .o_rise     (rd_rise),
    .o_fall     (rd_fall)
  );

  assign stb = '{cs_n: cs_level, cs_fall: cs_fall, cs_rise: cs_rise, rd_n: rd_level,
                 rd_fall: rd_fall & ~cs_level, sclk_rise: rd_rise & ~cs_level,
                 sclk_fall: rd_fall & ~cs_level};

  // --------------------------------------------------------------------------
  // Mode and power decode
  // --------------------------------------------------------------------------

  // Select mode from interface select and the msb/byte select pin.
  wire arp_pkg::arp_mode_t mode =
    (i_interface_select == `ARP_IFSEL_PARALLEL) ? arp_pkg::ARP_MODE_PAR16 :
    (i_msb_or_byte_select == `ARP_MSBSEL_BYTE)  ? arp_pkg::ARP_MODE_BYTE  :
                                                  arp_pkg::ARP_MODE_SERIAL;

  // Power-down follows the pins directly, as it may happen at any time.
  assign o_power_state = i_standby_n ? arp_pkg::ARP_PWR_ACTIVE :
                         (i_range == `ARP_RANGE_STANDBY) ? arp_pkg::ARP_PWR_STANDBY :
                                                          arp_pkg::ARP_PWR_SHUTDOWN;

  // --------------------------------------------------------------------------
  // Frame sequencing state
  // --------------------------------------------------------------------------

  logic [4:0]  rd_count_q;   // Read falls seen in this frame; room for 16 byte reads and one more.
  logic [4:0]  rd_count_d;
  logic [4:0]  bit_count_q;  // Serial bit within the current channel.
  logic [4:0]  bit_count_d;
  logic [1:0]  ser_ch_q;     // Channel index within each serial line.
  logic [1:0]  ser_ch_d;
  logic [4:0]  sclk_falls_q; // Serial clock falls, saturating at the flag point.
  logic [4:0]  sclk_falls_d;
  logic        ser_shift;    // Shift request on serial clock rise.

  // Selects one channel result from the flattened input.
  function automatic logic [15:0] chan_word(input logic [NUM_CH*RBITS-1:0] all,
                                            input logic [4:0] idx);
    chan_word = all[idx*RBITS +: 16];
  endfunction

  // Serial bit shifts on each serial clock rise after the first bit.
  assign ser_shift = (mode == arp_pkg::ARP_MODE_SERIAL) & stb.sclk_rise;

  // Next-state of the counters; select fall starts every frame afresh.
  always_comb
  begin
    rd_count_d   = rd_count_q;
    bit_count_d  = bit_count_q;
    ser_ch_d     = ser_ch_q;
    sclk_falls_d = sclk_falls_q;
    if (stb.cs_fall)
    begin
      rd_count_d   = 5'h00;
      bit_count_d  = 5'h00;
      ser_ch_d     = 2'h0;
      sclk_falls_d = 5'h00;
    end
    else if (stb.rd_fall && mode != arp_pkg::ARP_MODE_SERIAL)
    begin
      // Saturate at 5'h1f so the count never wraps back to 1 and the flag stays low.
      if (rd_count_q != 5'h1f)
        rd_count_d = rd_count_q + 5'h01;
    end
    else if (ser_shift)
    begin
      if (bit_count_q == 5'h0f)
      begin
        bit_count_d = 5'h00;
        ser_ch_d    = ser_ch_q + 2'h1;
      end
      else
      begin
        bit_count_d = bit_count_q + 5'h01;
      end
    end
    if (!stb.cs_fall && stb.sclk_fall && mode == arp_pkg::ARP_MODE_SERIAL &&
        sclk_falls_q != `ARP_FLAG_SCLK_FALLS)
      sclk_falls_d = sclk_falls_q + 5'h01;
  end

  // Counter registers.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rd_count_q   <= 5'h00;
      bit_count_q  <= 5'h00;
      ser_ch_q     <= 2'h0;
      sclk_falls_q <= 5'h00;
    end
    else
    begin
      rd_count_q   <= rd_count_d;
      bit_count_q  <= bit_count_d;
      ser_ch_q     <= ser_ch_d;
      sclk_falls_q <= sclk_falls_d;
    end
  end

  // --------------------------------------------------------------------------
  // Output data selection
  // --------------------------------------------------------------------------

  // Parallel: rd_count 1 is channel 1.
  wire [4:0]  par_idx   = rd_count_q - 5'h01;
  wire [15:0] par_word  = chan_word(i_results, par_idx);
  // Byte mode: two reads per channel, order from the byte order pin.
  wire [4:0]  byte_idx  = 5'((rd_count_q - 5'h01) >> 1);
  wire        second_b  = ~rd_count_q[0];
  wire [15:0] byte_word = chan_word(i_results, byte_idx);
  wire        send_high = i_byte_order_select ^ second_b;
  wire [7:0]  byte_out  = send_high ? byte_word[15:8] : byte_word[7:0];
  // Serial: line A channels 1-4, line B channels 5-8, MSB first.
  wire [15:0] word_a    = chan_word(i_results, {3'b000, ser_ch_q});
  wire [15:0] word_b    = chan_word(i_results, 5'(`ARP_CH_PER_LINE) + {3'b000, ser_ch_q});
  wire [3:0]  bit_sel   = 4'(5'h0f - bit_count_q);

  // Parallel reads are valid only for channels that exist.
  wire        valid_rd  = (rd_count_q != 5'h00) &&
                          (mode == arp_pkg::ARP_MODE_BYTE ? byte_idx < 5'(NUM_CH)
                                                          : par_idx < 5'(NUM_CH));
  wire        bus_en    = ~stb.cs_n & ~stb.rd_n & valid_rd;

  arp_pkg::arp_bus_t bus_d;   // Next pin bundle.
  arp_pkg::arp_bus_t bus_q;   // Registered pin bundle.
  logic              sa_q;    // Serial line A.
  logic              sb_q;    // Serial line B.
  logic              soe_q;   // Serial lines enable.

  // Drive pattern per mode; bit 8 never driven in byte mode.
  always_comb
  begin
    bus_d = '{data: 16'h0000, oe: 16'h0000};
    if (bus_en && mode == arp_pkg::ARP_MODE_PAR16)
      bus_d = '{data: par_word, oe: 16'hffff};
    else if (bus_en && mode == arp_pkg::ARP_MODE_BYTE)
      bus_d = '{data: {8'h00, byte_out}, oe: 16'h00ff};
  end

  // Pin registers; select high floats everything.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      bus_q <= '{data: 16'h0000, oe: 16'h0000};
      sa_q  <= 1'b0;
      sb_q  <= 1'b0;
      soe_q <= 1'b0;
    end
    else
    begin
      bus_q <= bus_d;
      sa_q  <= word_a[bit_sel];
      sb_q  <= word_b[bit_sel];
      soe_q <= ~stb.cs_n & (mode == arp_pkg::ARP_MODE_SERIAL);
    end
  end

  assign o_result_bus    = bus_q.data;
  assign o_result_bus_oe = bus_q.oe;
  assign o_serial_out_a  = sa_q;
  assign o_serial_out_b  = sb_q;
  assign o_serial_oe     = soe_q;

  // --------------------------------------------------------------------------
  // First-channel flag
  // --------------------------------------------------------------------------

  logic flag_q;     // Flag level.
  logic flag_oe_q;  // Flag drive enable.

  // Flag value per mode, from the counters of the frame.
  wire flag_d =
    (mode == arp_pkg::ARP_MODE_PAR16)  ? (rd_count_d == 5'h01) :
    (mode == arp_pkg::ARP_MODE_BYTE)   ? (rd_count_d == 5'h01 || rd_count_d == 5'h02) :
                                         (sclk_falls_d != `ARP_FLAG_SCLK_FALLS);

  // Enable on select fall, float on select rise.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flag_q    <= 1'b0;
      flag_oe_q <= 1'b0;
    end
    else
    begin
      flag_q    <= flag_d & ~stb.cs_n;
      if (stb.cs_fall)
        flag_oe_q <= 1'b1;
      else if (stb.cs_rise)
        flag_oe_q <= 1'b0;
    end
  end

  assign o_first_channel_flag    = flag_q;
  assign o_first_channel_flag_oe = flag_oe_q;

endmodule

`default_nettype wire

// *** design/arp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Three-stage synchroniser with edge detection
// ----------------------------------------------------------------------------
// The first stage is read only by the second; a change counts once the
// second and third stages agree on a new level.
module arp_sync
#(
  parameter logic RESET_LEVEL = 1'b1
)
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  // Asynchronous pin
  input  wire logic i_pin,
  // Filtered level and edges
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic [2:0] stage_q;  // Metastability chain.
  logic       level_q;  // Accepted level.

  // Shift the pin through three flops.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      stage_q <= {3{RESET_LEVEL}};
    else
      stage_q <= {stage_q[1:0], i_pin};
  end

  // Accept a new level when stages two and three agree.
  wire agree = (stage_q[1] == stage_q[2]);

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      level_q <= RESET_LEVEL;
    else if (agree)
      level_q <= stage_q[2];
  end

  assign o_level = level_q;
  assign o_rise  = agree & stage_q[2] & ~level_q;
  assign o_fall  = agree & ~stage_q[2] & level_q;

endmodule

`default_nettype wire

// *** testbench/arp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Host controller model
// ----------------------------------------------------------------------------
module arp_host_model
(
  // Clock
  input  wire logic i_core_clk,
  // Host strobes, both idle high
  output var logic  o_cs_n,
  output var logic  o_rd_sclk
);
  // Strobes start idle so no frame opens during reset.
  initial
  begin
    o_cs_n    = 1'b1;
    o_rd_sclk = 1'b1;
  end

  // Waits a number of falling core clock edges.
  task automatic idle(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // Moves chip select on a falling edge; each fall opens a new frame.
  task automatic select(input logic lvl);
    @(negedge i_core_clk);
    o_cs_n = lvl;
  endtask

  // Moves the read strobe or serial clock; it stands still between frames.
  task automatic strobe(input logic lvl);
    @(negedge i_core_clk);
    o_rd_sclk = lvl;
  endtask
endmodule

`default_nettype wire

// *** testbench/arp_readout_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Pin relation checker
// ----------------------------------------------------------------------------
module arp_readout_chk
(
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  // Host strobes and mode pins
  input  wire logic              i_cs_n,
  input  wire logic              i_rd_sclk,
  input  wire logic              i_interface_select,
  input  wire logic              i_msb_or_byte_select,
  input  wire logic              i_standby_n,
  input  wire logic              i_range,
  // Outputs under watch
  input  wire logic [15:0]       o_result_bus_oe,
  input  wire logic              o_serial_oe,
  input  wire logic              o_first_channel_flag,
  input  wire logic              o_first_channel_flag_oe,
  input  wire arp_pkg::arp_pwr_t o_power_state
);
  // Mode decode, and a short history of both strobes being low.
  wire logic       par_mode = !i_interface_select;
  wire logic       byte_mode = i_interface_select && i_msb_or_byte_select;
  wire logic       ser_mode = i_interface_select && !i_msb_or_byte_select;
  wire logic       both_low = !i_cs_n && !i_rd_sclk;
  logic      [5:0] hist_q;

  // The history lets a bus enable be traced to its strobe despite sync delay.
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      hist_q <= 6'h00;
    else
      hist_q <= {hist_q[4:0], both_low};
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  property p_flag_release; $fell(i_cs_n) |-> ##[3:6] o_first_channel_flag_oe; endproperty
  property p_cs_rise_float;
    $rose(i_cs_n) |-> ##[3:6] (o_result_bus_oe == 16'h0000 && !o_serial_oe
                               && !o_first_channel_flag_oe);
  endproperty
  property p_ser_flag_up;
    (ser_mode && $fell(i_cs_n)) |-> ##[3:6] (o_first_channel_flag && o_serial_oe);
  endproperty
  property p_par_flag_drop;
    (par_mode && o_first_channel_flag && $fell(i_rd_sclk)) |-> ##[3:6] !o_first_channel_flag;
  endproperty
  property p_par_word; (par_mode && o_result_bus_oe != 0) |-> o_result_bus_oe == 16'hffff;
  endproperty
  property p_bus_strobed; (o_result_bus_oe != 0) |-> (hist_q[5:2] != 4'h0); endproperty
  property p_byte_pins; (byte_mode && o_result_bus_oe != 0) |-> o_result_bus_oe == 16'h00ff;
  endproperty
  property p_bit8_float; byte_mode |-> !o_result_bus_oe[8]; endproperty
  property p_ser_only; o_serial_oe |-> (ser_mode && o_result_bus_oe == 16'h0000); endproperty
  property p_power;
    o_power_state == (i_standby_n ? arp_pkg::ARP_PWR_ACTIVE :
                      (i_range ? arp_pkg::ARP_PWR_STANDBY : arp_pkg::ARP_PWR_SHUTDOWN));
  endproperty

  a_flag_release: assert property (p_flag_release) else $error("flag stays floating");
  a_cs_rise_float: assert property (p_cs_rise_float) else $error("outputs still driven");
  a_ser_flag_up: assert property (p_ser_flag_up) else $error("serial flag not raised");
  a_par_flag_drop: assert property (p_par_flag_drop) else $error("flag not dropped");
  a_par_word: assert property (p_par_word) else $error("partial parallel word");
  a_bus_strobed: assert property (p_bus_strobed) else $error("bus driven unstrobed");
  a_byte_pins: assert property (p_byte_pins) else $error("byte mode enable wrong");
  a_bit8_float: assert property (p_bit8_float) else $error("bit 8 driven in byte mode");
  a_ser_only: assert property (p_ser_only) else $error("serial lines out of mode");
  a_power: assert property (p_power) else $error("power state decode wrong");

  c_par: cover property (par_mode && o_result_bus_oe == 16'hffff);
  c_byte: cover property (byte_mode && o_result_bus_oe == 16'h00ff);
  c_ser: cover property (o_serial_oe && o_first_channel_flag);
endmodule

bind arp_readout arp_readout_chk i_arp_readout_chk
(
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .i_rd_sclk(i_rd_sclk),
  .i_interface_select(i_interface_select), .i_msb_or_byte_select(i_msb_or_byte_select),
  .i_standby_n(i_standby_n), .i_range(i_range), .o_result_bus_oe(o_result_bus_oe),
  .o_serial_oe(o_serial_oe), .o_first_channel_flag(o_first_channel_flag),
  .o_first_channel_flag_oe(o_first_channel_flag_oe), .o_power_state(o_power_state)
);

`default_nettype wire

// *** testbench/arp_readout_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Readout port testbench
// ----------------------------------------------------------------------------
module arp_readout_tb;
  logic              clk;
  logic              rst_n;
  logic [127:0]      results;
  logic              ifsel;
  logic              msbsel;
  logic              border;
  logic              standby_n_n;
  logic              rng;
  wire logic         cs_n;
  wire logic         rd_sclk;
  logic [15:0]       bus;
  logic [15:0]       bus_oe;
  logic              sa;
  logic              sb;
  logic              soe;
  logic              flag;
  logic              flag_oe;
  arp_pkg::arp_pwr_t pwr;
  logic [15:0]       wa;
  logic [15:0]       wb;
  logic [15:0]       base;
  int                errors;
  int                total_checks;

  arp_host_model i_arp_host_model (.i_core_clk(clk), .o_cs_n(cs_n), .o_rd_sclk(rd_sclk));

  arp_readout i_arp_readout
  (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_results(results), .i_cs_n(cs_n),
    .i_rd_sclk(rd_sclk), .i_interface_select(ifsel), .i_msb_or_byte_select(msbsel),
    .i_byte_order_select(border), .i_standby_n(standby_n_n), .i_range(rng),
    .o_result_bus(bus), .o_result_bus_oe(bus_oe), .o_serial_out_a(sa),
    .o_serial_out_b(sb), .o_serial_oe(soe), .o_first_channel_flag(flag),
    .o_first_channel_flag_oe(flag_oe), .o_power_state(pwr)
  );

  // Result of channel n; both bytes of the word differ between channels.
  function automatic logic [15:0] res(input int n);
    return base + 16'(n) * 16'h1203;
  endfunction

  // Loads a fresh result set, so that every frame reads different words.
  task automatic load(input logic [15:0] b);
    base = b;
    for (int n = 1; n <= 8; n++)
      results[(n-1)*16 +: 16] = res(n);
  endtask

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One read strobe: data, enables and flag while low, float once high.
  task automatic rd_cycle(input logic [15:0] eb, input logic [15:0] eo, input logic ef);
    i_arp_host_model.strobe(1'b0);
    i_arp_host_model.idle(6);
    check(bus_oe, eo);
    check(bus & eo, eb & eo);
    check(16'(flag), 16'(ef));
    i_arp_host_model.strobe(1'b1);
    i_arp_host_model.idle(6);
    check(bus_oe, 16'h0000);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A hang is cut short and counted as a mismatch.
  initial
  begin
    #2000000;
    errors++;
    stop_test();
  end

  initial
  begin
    errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    ifsel = 1'b0;
    msbsel = 1'b0;
    border = 1'b0;
    standby_n_n = 1'b1;
    rng = 1'b1;
    load(16'h8e31);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    i_arp_host_model.idle(2);
    // Parallel frame: eight reads, then one past the last channel.
    i_arp_host_model.select(1'b0);
    i_arp_host_model.idle(6);
    check(16'(flag_oe), 16'h0001);
    for (int k = 1; k <= 9; k++)
      rd_cycle((k <= 8) ? res(k) : 16'h0000, (k <= 8) ? 16'hffff : 16'h0000, k == 1);
    i_arp_host_model.select(1'b1);
    i_arp_host_model.idle(6);
    check(16'(flag_oe), 16'h0000);
    // Reset inside a second frame floats the flag at once and opens nothing.
    i_arp_host_model.select(1'b0);
    i_arp_host_model.idle(6);
    rst_n = 1'b0;
    #1;
    check(16'({flag, flag_oe}), 16'h0000);
    i_arp_host_model.select(1'b1);
    rst_n = 1'b1;
    i_arp_host_model.idle(6);
    check(16'({flag, flag_oe}), 16'h0000);
    // Byte frames in both byte orders, sixteen reads and one refused.
    ifsel = 1'b1;
    msbsel = 1'b1;
    for (int o = 0; o < 2; o++)
    begin
      border = 1'(o);
      load(16'h4c7a + 16'(o));
      i_arp_host_model.select(1'b0);
      i_arp_host_model.idle(6);
      for (int k = 0; k < 16; k++)
      begin
        wa = res(k / 2 + 1);
        wb = ((k % 2 == 0) == (o == 1)) ? {8'h00, wa[15:8]} : {8'h00, wa[7:0]};
        rd_cycle(wb, 16'h00ff, k < 2);
      end
      rd_cycle(16'h0000, 16'h0000, 1'b0);
      i_arp_host_model.select(1'b1);
      i_arp_host_model.idle(6);
    end
    // Serial frame: unused pins held low, four channels on each line.
    load(16'h1d95);
    msbsel = 1'b0;
    border = 1'b0;
    i_arp_host_model.select(1'b0);
    i_arp_host_model.idle(6);
    check(16'({soe, flag}), 16'h0003);
    for (int b = 0; b < 64; b++)
    begin
      wa = res(b / 16 + 1);
      wb = res(b / 16 + 5);
      i_arp_host_model.strobe(1'b0);
      i_arp_host_model.idle(2);
      check(16'({sa, sb}), 16'({wa[15 - b % 16], wb[15 - b % 16]}));
      check(16'(flag), 16'(b < 16));
      i_arp_host_model.idle(1);
      i_arp_host_model.strobe(1'b1);
      i_arp_host_model.idle(3);
    end
    i_arp_host_model.select(1'b1);
    i_arp_host_model.idle(6);
    check(16'({soe, flag_oe}), 16'h0000);
    // Power decode over every standby and range combination.
    for (int p = 0; p < 4; p++)
    begin
      i_arp_host_model.idle(1);
      {standby_n_n, rng} = 2'(p);
      #1;
      check(16'(pwr), standby_n_n ? 16'(arp_pkg::ARP_PWR_ACTIVE) :
            (rng ? 16'(arp_pkg::ARP_PWR_STANDBY) : 16'(arp_pkg::ARP_PWR_SHUTDOWN)));
    end
    stop_test();
  end
endmodule

`default_nettype wire
